/* rtl/channel_sequencer_instruction_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_sequencer_instruction_exec (
  input  wire logic                      CLK,
  input  wire logic                      RESET,
  input  wire logic                      CE,
  input  wire logic                      AUTO_MODE,
  input  wire logic                      WORD_VALID,
  input  wire logic [15:0]               WORD_DATA,
  input  wire logic [7:0]                PC_IN,
  input  wire logic                      TIME_DONE,
  input  wire logic [14:0]               LAST_VOLTAGE,
  input  wire logic                      LOOP_HIGH_SIDE,
  input  wire logic                      LOOP_LOW_SIDE,
  output logic                           WORD_READY,
  output logic                           HALTED,
  output logic                           SEQUENCE_FINISHED_FLAG,
  output logic                           HIGH_SIDE_DRIVE,
  output logic                           LOW_SIDE_DRIVE,
  output logic                           FILTER_HOLD,
  output logic                           MEASURE_ENABLE,
  output logic                           BATTERY_SWITCH_VALUE,
  output logic                           INSTR_ACTIVE,
  output logic                           INSTR_DONE,
  output logic                           JUMP_VALID,
  output logic [7:0]                     JUMP_ADDR,
  output seq_exec_pkg::params_type       PARAMS,
  output logic                           VOLTAGE_SET_RELATIVE,
  output logic                           VOLTAGE_GATE_RELATIVE,
  output logic [1:0]                     INSTRUCTION_KIND_FIELD
);
  import seq_exec_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  exec_state_type state_ff,   nxt_state;
  logic [15:0]    header_ff,  nxt_header;
  logic [7:0]     pending_ff, nxt_pending;
  params_type     params_ff,  nxt_params;
  logic           halted_ff,  nxt_halted;
  logic           finished_ff, nxt_finished;
  logic           vrel_ff,    nxt_vrel;
  logic           grel_ff,    nxt_grel;
  logic [7:0]     loop_iteration_count_ff, nxt_loop_iteration_count;
  logic [7:0]     loop_addr_ff, nxt_loop_addr;
  logic           done_ff,    nxt_done;
  logic           jump_ff,    nxt_jump;
  logic [7:0]     hdr_addr_ff, nxt_hdr_addr;
  logic [14:0]    voltage_setpoint_abs;
  logic [14:0]    vgate_abs;
  logic [2:0]     slot;
  logic [1:0]     kind;
  logic [7:0]     dec_cnt;

  rel_resolve u_voltage_setpoint (
    .raw_word     (WORD_DATA),
    .last_voltage (LAST_VOLTAGE),
    .resolved     (voltage_setpoint_abs)
  );
  rel_resolve u_vgate (
    .raw_word     (WORD_DATA),
    .last_voltage (LAST_VOLTAGE),
    .resolved     (vgate_abs)
  );

  assign kind = header_ff[HDR_KIND_LO +: 2];
  assign slot = first_slot(pending_ff);
  // ready in idle and in a load turn with a slot pending, whatever CE is: the empty-mask turn and the run refuse it,
  // so a source must qualify the handshake with CE; words in the reserved slots are taken and discarded
  assign WORD_READY = (state_ff == ST_IDLE) ||
                      ((state_ff == ST_LOAD) && (pending_ff != SLOTS_NONE));

  // ------------------------------------------------------------
  // decode and execute
  // ------------------------------------------------------------
  always_comb begin
    nxt_state     = state_ff;
    nxt_header    = header_ff;
    nxt_pending   = pending_ff;
    nxt_params    = params_ff;
    nxt_halted    = halted_ff;
    nxt_finished  = finished_ff;
    nxt_vrel      = vrel_ff;
    nxt_grel      = grel_ff;
    nxt_loop_iteration_count  = loop_iteration_count_ff;
    nxt_loop_addr = loop_addr_ff;
    nxt_hdr_addr  = hdr_addr_ff;
    nxt_done      = 1'b0;
    nxt_jump      = 1'b0;
    dec_cnt       = 8'(loop_iteration_count_ff - 8'h01);
    unique case (state_ff)
      ST_IDLE: begin
        if (WORD_VALID) begin
          nxt_header   = WORD_DATA;
          nxt_hdr_addr = PC_IN;
          nxt_pending  = slot_mask(WORD_DATA, AUTO_MODE);
          if (WORD_DATA[1:0] == KIND_HALT) begin
            nxt_halted   = 1'b1;
            nxt_finished = finished_ff | AUTO_MODE;
            nxt_state    = ST_IDLE;
          end else begin
            nxt_halted   = 1'b0;
            nxt_finished = 1'b0;
            nxt_state    = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        if (pending_ff == SLOTS_NONE) begin
          nxt_state = ST_RUN;
        end else if (WORD_VALID) begin
          nxt_pending[slot] = 1'b0;
          unique case (slot)
            SLOT_CURRENT_SETPOINT: nxt_params.current_setpoint = WORD_DATA[14:0];
            SLOT_VOLTAGE_SETPOINT: begin
              nxt_params.voltage_setpoint = voltage_setpoint_abs;
              nxt_vrel = WORD_DATA[REL_BIT];
            end
            SLOT_RSV2, SLOT_RSV3: begin
            end
            SLOT_ILIM: nxt_params.current_end_limit = WORD_DATA[14:0];
            SLOT_VLIM: begin
              nxt_params.voltage_gate_limit = vgate_abs;
              nxt_grel = WORD_DATA[REL_BIT];
            end
            SLOT_TLIM: nxt_params.time_limit = WORD_DATA;
            SLOT_LOOP: begin
              nxt_params.loop_iteration_count = WORD_DATA[7:0];
              nxt_loop_addr = hdr_addr_ff;
              if (loop_iteration_count_ff == LOOP_ZERO) begin
                nxt_loop_iteration_count = WORD_DATA[7:0];
              end
            end
          endcase
        end
      end
      ST_RUN: begin
        if (TIME_DONE) begin
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
          if (AUTO_MODE && header_ff[HDR_LOOP_END] && loop_iteration_count_ff != LOOP_ZERO) begin
            nxt_loop_iteration_count = dec_cnt;
            nxt_jump     = (dec_cnt != LOOP_ZERO);
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_ff     <= ST_IDLE;
      header_ff    <= WORD_ZERO;
      pending_ff   <= SLOTS_NONE;
      params_ff    <= '0;
      halted_ff    <= 1'b1;
      finished_ff  <= 1'b0;
      vrel_ff      <= 1'b0;
      grel_ff      <= 1'b0;
      loop_iteration_count_ff  <= LOOP_ZERO;
      loop_addr_ff <= LOOP_ZERO;
      hdr_addr_ff  <= LOOP_ZERO;
      done_ff      <= 1'b0;
      jump_ff      <= 1'b0;
    end else if (CE) begin
      state_ff     <= nxt_state;
      header_ff    <= nxt_header;
      pending_ff   <= nxt_pending;
      params_ff    <= nxt_params;
      halted_ff    <= nxt_halted;
      finished_ff  <= nxt_finished;
      vrel_ff      <= nxt_vrel;
      grel_ff      <= nxt_grel;
      loop_iteration_count_ff  <= nxt_loop_iteration_count;
      loop_addr_ff <= nxt_loop_addr;
      hdr_addr_ff  <= nxt_hdr_addr;
      done_ff      <= nxt_done;
      jump_ff      <= nxt_jump;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic run_cd;
  logic run_rest;
  assign run_cd   = (state_ff == ST_RUN) && !halted_ff && kind != KIND_REST && kind != KIND_HALT;
  assign run_rest = (state_ff != ST_IDLE) && kind == KIND_REST;

  assign HIGH_SIDE_DRIVE = run_cd & LOOP_HIGH_SIDE;
  assign LOW_SIDE_DRIVE  = run_cd & LOOP_LOW_SIDE;
  assign FILTER_HOLD     = run_rest;
  assign MEASURE_ENABLE  = 1'b1;
  assign HALTED                 = halted_ff;
  assign SEQUENCE_FINISHED_FLAG = finished_ff;
  assign BATTERY_SWITCH_VALUE   = header_ff[HDR_SWITCH];
  assign INSTR_ACTIVE           = (state_ff == ST_RUN);
  assign INSTR_DONE             = done_ff;
  assign JUMP_VALID             = jump_ff;
  assign JUMP_ADDR              = loop_addr_ff;
  assign PARAMS                 = params_ff;
  assign VOLTAGE_SET_RELATIVE   = vrel_ff;
  assign VOLTAGE_GATE_RELATIVE  = grel_ff;
  assign INSTRUCTION_KIND_FIELD = kind;

endmodule // channel_sequencer_instruction_exec
`default_nettype wire

/* rtl/seq_exec_pkg.sv */
package seq_exec_pkg;

  // ------------------------------------------------------------
  // instruction encoding
  // ------------------------------------------------------------
  localparam int unsigned WORD_W       = 16;
  localparam logic [1:0]  KIND_HALT    = 2'h0;
  localparam logic [1:0]  KIND_REST    = 2'h1;
  localparam int unsigned HDR_KIND_LO  = 0;
  localparam int unsigned HDR_CV_BIT   = 2;
  localparam int unsigned HDR_CC_BIT   = 3;
  localparam int unsigned HDR_SWITCH   = 9;
  localparam int unsigned HDR_LOOP_1ST = 10;
  localparam int unsigned HDR_LOOP_END = 11;
  localparam int unsigned REL_BIT      = 15;
  localparam int unsigned LIMIT_W      = 15;

  // payload slot numbers of charge/discharge
  localparam logic [2:0] SLOT_CURRENT_SETPOINT   = 3'h0;
  localparam logic [2:0] SLOT_VOLTAGE_SETPOINT   = 3'h1;
  localparam logic [2:0] SLOT_RSV2   = 3'h2;
  localparam logic [2:0] SLOT_RSV3   = 3'h3;
  localparam logic [2:0] SLOT_ILIM   = 3'h4;
  localparam logic [2:0] SLOT_VLIM   = 3'h5;
  localparam logic [2:0] SLOT_TLIM   = 3'h6;
  localparam logic [2:0] SLOT_LOOP   = 3'h7;

  localparam logic [7:0]  LOOP_ZERO  = 8'h00;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [7:0]  SLOTS_NONE = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } exec_state_type;

  typedef struct packed {
    logic [14:0] current_setpoint;
    logic [14:0] voltage_setpoint;
    logic [14:0] current_end_limit;
    logic [14:0] voltage_gate_limit;
    logic [15:0] time_limit;
    logic [7:0]  loop_iteration_count;
  } params_type;

  // ------------------------------------------------------------
  // payload-slot mask from header
  // ------------------------------------------------------------
  function automatic logic [7:0] slot_mask(input logic [15:0] hdr, input logic autom);
    logic [7:0] m;
    m = SLOTS_NONE;
    if (hdr[1:0] == KIND_REST) begin
      m[SLOT_TLIM] = 1'b1;
    end else if (hdr[1:0] != KIND_HALT) begin
      m[SLOT_CURRENT_SETPOINT] = hdr[HDR_CC_BIT];
      m[SLOT_VOLTAGE_SETPOINT] = hdr[HDR_CV_BIT];
      m[SLOT_RSV2] = 1'b1;
      m[SLOT_RSV3] = 1'b1;
      m[SLOT_ILIM] = hdr[HDR_CV_BIT];
      m[SLOT_VLIM] = hdr[HDR_CC_BIT];
      m[SLOT_TLIM] = 1'b1;
    end
    if (hdr[1:0] != KIND_HALT) begin
      m[SLOT_LOOP] = autom & hdr[HDR_LOOP_1ST];
    end
    return m;
  endfunction

  // lowest set bit index of a mask
  function automatic logic [2:0] first_slot(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

endpackage

/* rtl/rel_resolve.sv */
`timescale 1ns/1ps
`default_nettype none
module rel_resolve (
  input  wire logic [15:0] raw_word,
  input  wire logic [14:0] last_voltage,
  output logic      [14:0] resolved
);
  import seq_exec_pkg::*;

  // offset wraps in 15 bits; the sign of the offset is not defined
  always_comb begin
    if (raw_word[REL_BIT]) begin
      resolved = 15'(raw_word[14:0] + last_voltage);
    end else begin
      resolved = raw_word[14:0];
    end
  end
endmodule // rel_resolve
`default_nettype wire

/* tb/exec_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module exec_checker
  import seq_exec_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       CE,
  input wire logic       AUTO_MODE,
  input wire logic       TIME_DONE,
  input wire logic       LOOP_HIGH_SIDE,
  input wire logic       LOOP_LOW_SIDE,
  input wire logic       WORD_READY,
  input wire logic       HALTED,
  input wire logic       SEQUENCE_FINISHED_FLAG,
  input wire logic       HIGH_SIDE_DRIVE,
  input wire logic       LOW_SIDE_DRIVE,
  input wire logic       FILTER_HOLD,
  input wire logic       MEASURE_ENABLE,
  input wire logic       INSTR_ACTIVE,
  input wire logic       INSTR_DONE,
  input wire logic       JUMP_VALID,
  input wire params_type PARAMS,
  input wire logic [1:0] INSTRUCTION_KIND_FIELD
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_halt_drv; HALTED |-> !HIGH_SIDE_DRIVE && !LOW_SIDE_DRIVE; endproperty
  a_halt_drv: assert property (p_halt_drv) else $error("drive while halted");
  property p_fin; $rose(HALTED) |-> SEQUENCE_FINISHED_FLAG == $past(AUTO_MODE); endproperty
  a_fin: assert property (p_fin) else $error("finished flag wrong at halt");
  property p_rest_drv; FILTER_HOLD |-> !HIGH_SIDE_DRIVE && !LOW_SIDE_DRIVE; endproperty
  a_rest_drv: assert property (p_rest_drv) else $error("drive during rest");
  property p_run_drv;
    INSTR_ACTIVE && INSTRUCTION_KIND_FIELD[1]
      |-> HIGH_SIDE_DRIVE == LOOP_HIGH_SIDE && LOW_SIDE_DRIVE == LOOP_LOW_SIDE;
  endproperty
  a_run_drv: assert property (p_run_drv) else $error("drive not from loop");
  property p_meas; MEASURE_ENABLE; endproperty
  a_meas: assert property (p_meas) else $error("measurement stopped");
  property p_hold; INSTR_ACTIVE |-> FILTER_HOLD == (INSTRUCTION_KIND_FIELD == KIND_REST); endproperty
  a_hold: assert property (p_hold) else $error("filter hold wrong");
  property p_end; INSTR_ACTIVE && TIME_DONE && CE |=> INSTR_DONE && !INSTR_ACTIVE; endproperty
  a_end: assert property (p_end) else $error("no end after time limit");
  property p_frozen; INSTR_ACTIVE |=> $stable(PARAMS); endproperty
  a_frozen: assert property (p_frozen) else $error("parameters moved in run");
  property p_jump; JUMP_VALID |-> INSTR_DONE; endproperty
  a_jump: assert property (p_jump) else $error("jump without end");
  property p_refuse; INSTR_ACTIVE |-> !WORD_READY; endproperty
  a_refuse: assert property (p_refuse) else $error("word accepted in run");
  c_halt: cover property ($rose(HALTED) && SEQUENCE_FINISHED_FLAG);
  c_jump: cover property (JUMP_VALID);
  c_rest: cover property (INSTR_ACTIVE && FILTER_HOLD);
endmodule // exec_checker

bind channel_sequencer_instruction_exec exec_checker u_chk (
  .CLK(CLK), .RESET(RESET), .CE(CE), .AUTO_MODE(AUTO_MODE), .TIME_DONE(TIME_DONE),
  .LOOP_HIGH_SIDE(LOOP_HIGH_SIDE), .LOOP_LOW_SIDE(LOOP_LOW_SIDE), .WORD_READY(WORD_READY),
  .HALTED(HALTED), .SEQUENCE_FINISHED_FLAG(SEQUENCE_FINISHED_FLAG),
  .HIGH_SIDE_DRIVE(HIGH_SIDE_DRIVE), .LOW_SIDE_DRIVE(LOW_SIDE_DRIVE),
  .FILTER_HOLD(FILTER_HOLD), .MEASURE_ENABLE(MEASURE_ENABLE), .INSTR_ACTIVE(INSTR_ACTIVE),
  .INSTR_DONE(INSTR_DONE), .JUMP_VALID(JUMP_VALID), .PARAMS(PARAMS),
  .INSTRUCTION_KIND_FIELD(INSTRUCTION_KIND_FIELD)
);
`default_nettype wire

/* tb/word_source.sv */
`timescale 1ns/1ps
`default_nettype none
module word_source (
  input  wire logic  clk,
  input  wire logic  ready,
  input  wire logic  ce,
  output logic       valid,
  output logic [15:0] data,
  output logic [7:0] pc_in
);
  initial begin
    valid = 1'b0;
    data = 16'h0000;
    pc_in = 8'h00;
  end
  task automatic send(input logic [15:0] w, input logic [7:0] pc, output logic ok);
    logic r;
    ok = 1'b0;
    valid <= 1'b1;
    data <= w;
    pc_in <= pc;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(negedge clk);
      r = ready & ce;
      @(posedge clk);
      ok = r;
    end
  endtask
  // released bus shows inverted data, not the last word
  task automatic release_bus();
    valid <= 1'b0;
    data <= ~data;
  endtask
endmodule // word_source
`default_nettype wire

/* tb/channel_sequencer_instruction_exec_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_sequencer_instruction_exec_bench;
  import seq_exec_pkg::*;
  logic       clk, reset, ce, auto_mode, time_done, hi_loop, lo_loop;
  logic       wv, rdy, halted, fin, hs, ls, hold, meas, sw, active, done, jv, vrel, grel;
  logic [14:0] last_v;
  logic [15:0] wd;
  logic [7:0] pc, jaddr;
  logic [1:0] kind;
  params_type prm;
  int         failures, total_checks;

  always #2 clk = ~clk;

  word_source src (.clk(clk), .ready(rdy), .ce(ce), .valid(wv), .data(wd), .pc_in(pc));

  channel_sequencer_instruction_exec dut (
    .CLK(clk), .RESET(reset), .CE(ce), .AUTO_MODE(auto_mode), .WORD_VALID(wv),
    .WORD_DATA(wd), .PC_IN(pc), .TIME_DONE(time_done), .LAST_VOLTAGE(last_v),
    .LOOP_HIGH_SIDE(hi_loop), .LOOP_LOW_SIDE(lo_loop), .WORD_READY(rdy), .HALTED(halted),
    .SEQUENCE_FINISHED_FLAG(fin), .HIGH_SIDE_DRIVE(hs), .LOW_SIDE_DRIVE(ls),
    .FILTER_HOLD(hold), .MEASURE_ENABLE(meas), .BATTERY_SWITCH_VALUE(sw),
    .INSTR_ACTIVE(active), .INSTR_DONE(done), .JUMP_VALID(jv), .JUMP_ADDR(jaddr),
    .PARAMS(prm), .VOLTAGE_SET_RELATIVE(vrel), .VOLTAGE_GATE_RELATIVE(grel),
    .INSTRUCTION_KIND_FIELD(kind)
  );

  task automatic results();
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic load(input logic [15:0] w [], input logic [7:0] at);
    logic ok;
    @(posedge clk);
    foreach (w[i]) begin
      src.send(w[i], at, ok);
      if (!ok) begin
        failures++;
        $display("mismatch %0t word not taken", $time);
        results();
      end
    end
    src.release_bus();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // one time-limit pulse, then the end pulse is awaited under a bound
  task automatic finish(input logic exp_jump);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    time_done <= 1'b1;
    @(posedge clk);
    time_done <= 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      #1;
      seen = done;
      if (seen) chk(jv, exp_jump, "jump");
      else @(posedge clk);
    end
    chk(seen, 1'b1, "done");
    if (!seen) begin
      results();
    end
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    auto_mode = 1'b1;
    time_done = 1'b0;
    hi_loop = 1'b1;
    lo_loop = 1'b0;
    last_v = 15'h0100;
    failures = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    chk(meas, 1'b1, "measure in reset");
    reset <= 1'b0;
    load('{16'h0000}, 8'h10);
    chk({halted, fin, hs, ls}, 4'h0C, "auto halt");
    chk(rdy, 1'b1, "halt has no payload");
    load('{16'h0601, 16'hA5C3, 16'h7703}, 8'h20);
    chk({kind, sw, hold, hs, ls, active, rdy}, 8'h72, "rest state");
    chk(prm.time_limit, 16'hA5C3, "rest time");
    chk(prm.loop_iteration_count, 8'h03, "loop count");
    finish(1'b0);
    load('{16'h0000}, 8'h24);
    chk({halted, fin, hs, ls}, 4'hC, "auto halt after run");
    load('{16'h000A, 16'hD234, 16'h0000, 16'h0000, 16'h8010, 16'h0040}, 8'h21);
    chk({hs, ls, hold, grel}, 4'h9, "cc run");
    chk(prm.current_setpoint, 15'h5234, "current setpoint");
    chk(prm.voltage_gate_limit, 15'h0110, "gate limit");
    chk(prm.time_limit, 16'h0040, "cc time");
    finish(1'b0);
    hi_loop <= 1'b0;
    lo_loop <= 1'b1;
    load('{16'h0807, 16'h8005, 16'h0000, 16'h0000, 16'hFF21, 16'h0100}, 8'h22);
    chk({hs, ls, vrel, kind}, 5'h0F, "cv run");
    chk(prm.voltage_setpoint, 15'h0105, "voltage setpoint");
    chk(prm.current_end_limit, 15'h7F21, "end limit");
    finish(1'b1);
    chk(jaddr, 8'h20, "loop start");
    auto_mode <= 1'b0;
    load('{16'h0401, 16'h0077}, 8'h30);
    chk({active, prm.time_limit}, 17'h10077, "manual rest no loop word");
    @(posedge clk);
    ce <= 1'b0;
    time_done <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({active, hold, done}, 3'h6, "enable low freezes run");
    @(posedge clk);
    ce <= 1'b1;
    time_done <= 1'b0;
    finish(1'b0);
    load('{16'h0000}, 8'h31);
    chk({halted, fin}, 2'h2, "manual halt");
    results();
  end
endmodule // channel_sequencer_instruction_exec_bench
`default_nettype wire
